//--- design/tgr_gesture.sv
// Function
// - read-only direction register: bit0 flags direction A, bit1 direction B, reset zero
// - writing one to clear bit7 wipes duration and direction flags
// - clear bit returns to zero by itself after the clear
// - only sense channels 0, 2, 4 and 6 take part in gestures
// - config bits 3:0 enable channels 0, 2, 4, 6; all reset to one
// - strict mode needs every enabled channel in the ordered sequence
// - tolerant mode still recognizes sequences with one skipped key
// - strict: 0-2-4-6 gives direction A, 6-4-2-0 gives direction B
// - tolerant: listed forward sequences give A, their reversals give B
// - mode bit is config bit4, resets to one (tolerant)
// - sampling interval is 512 oscillator periods times 1, 2, 4 or 8
// - judgment limit is interval times timeout setting times 16
// - time-base divider is two bits, resets to binary 10
// - duration is a 12-bit count of time-base ticks, 0 to 4095
// - sequence longer than the judgment limit is not a gesture
`timescale 1ns/100ps
`default_nettype none

module tgr_gesture (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sense_input_zero,
  input  wire logic        sense_input_two,
  input  wire logic        sense_input_four,
  input  wire logic        sense_input_six,
  output logic             irq
);

  tgr_pkg::tgr_config_type cfg;
  tgr_pkg::tgr_result_type result;
  tgr_pkg::tgr_state_type  state;
  logic [1:0]  timebase;
  logic [7:0]  timeout_setting;
  logic        clear_trigger;
  logic [2:0]  sts;
  logic [2:0]  mask;
  logic [3:0]  sync1;
  logic [3:0]  sync2;
  logic [3:0]  prev_touch;
  logic [12:0] pre_cnt;
  logic [1:0]  first_pos;
  logic [1:0]  last_pos;
  logic [2:0]  hits;
  logic        dir_up;
  logic        dir_known;
  logic [11:0] dur;

  // sense buttons come from another block; two flops before use
  wire [3:0] sense_raw = {sense_input_six, sense_input_four, sense_input_two, sense_input_zero};
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
        end else begin
          sync1[g] <= sense_raw[g];
          sync2[g] <= sync1[g];
        end
      end
    end
  endgenerate

  // apb decode; answer one cycle into the access phase
  wire        access    = psel & penable;
  wire        fire      = access & pready;
  wire        addr_ok   = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire [7:0]  idx       = paddr[9:2];
  wire        hit_dur   = addr_ok && (idx == tgr_pkg::TGR_IDX_DURATION);
  wire        hit_dir   = addr_ok && (idx == tgr_pkg::TGR_IDX_DIRECTION);
  wire        hit_clr   = addr_ok && (idx == tgr_pkg::TGR_IDX_CLEAR);
  wire        hit_cfg   = addr_ok && (idx == tgr_pkg::TGR_IDX_CONFIG);
  wire        hit_tb    = addr_ok && (idx == tgr_pkg::TGR_IDX_TIMEBASE);
  wire        hit_to    = addr_ok && (idx == tgr_pkg::TGR_IDX_TIMEOUT);
  wire        hit_sts   = addr_ok && (idx == tgr_pkg::TGR_IDX_IRQ_STAT);
  wire        hit_msk   = addr_ok && (idx == tgr_pkg::TGR_IDX_IRQ_MASK);
  wire        mapped    = hit_dur | hit_dir | hit_clr | hit_cfg | hit_tb | hit_to | hit_sts
                          | hit_msk;
  wire        wr        = fire & pwrite & mapped;
  // write-only registers read back as zero
  wire [31:0] read_data = hit_dur ? {20'h0, result.duration} :
                          hit_dir ? {30'h0, result.dir_b, result.dir_a} :
                          hit_sts ? {29'h0, sts} :
                          hit_msk ? {29'h0, mask} : 32'h0;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~mapped;
      prdata  <= (access & ~pready & ~pwrite) ? read_data : 32'h0;
    end
  end

  // software settings
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cfg             <= tgr_pkg::TGR_CONFIG_RST;
      timebase        <= tgr_pkg::TGR_TIMEBASE_RST;
      timeout_setting <= tgr_pkg::TGR_TIMEOUT_RST;
      mask            <= tgr_pkg::TGR_MASK_RST;
    end else begin
      if (wr && hit_cfg) begin
        cfg.mode <= pwdata[tgr_pkg::TGR_MODE_BIT];
        cfg.en   <= pwdata[3:0];
      end
      if (wr && hit_tb)
        timebase <= pwdata[1:0];
      if (wr && hit_to)
        timeout_setting <= pwdata[7:0];
      if (wr && hit_msk)
        mask <= pwdata[2:0];
    end
  end

  // clear strobe lives exactly one cycle, then drops on its own
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      clear_trigger <= 1'b0;
    else
      clear_trigger <= wr & hit_clr & pwdata[tgr_pkg::TGR_CLEAR_BIT] & ~clear_trigger;
  end

  // time base: 512 cycles shifted by the divider setting
  wire [12:0] tick_len = tgr_pkg::TGR_BASE_CYCLES << timebase;
  wire        tick     = (pre_cnt == tick_len - 13'h0001);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      pre_cnt <= 13'h0;
    else if (tick || pre_cnt >= tick_len)
      pre_cnt <= 13'h0;
    else
      pre_cnt <= pre_cnt + 13'h0001;
  end

  // only the four gesture channels, each gated by its enable
  wire [3:0]  touch      = sync2 & cfg.en;
  wire [3:0]  fresh      = touch & ~prev_touch;
  wire        one_fresh  = (fresh != 4'h0) && ((fresh & (fresh - 4'h1)) == 4'h0);
  wire        many_fresh = (fresh != 4'h0) && !one_fresh;
  wire [1:0]  fresh_pos  = fresh[0] ? 2'd0 : fresh[1] ? 2'd1 : fresh[2] ? 2'd2 : 2'd3;
  // judgment limit in ticks; the tick already scales with the divider
  wire [11:0] judge_lim  = {timeout_setting, 4'h0};
  wire        timed_out  = (dur >= judge_lim);
  wire        released   = (touch == 4'h0);

  // sequence evaluation over the recorded first and last key
  wire [1:0] lo_en    = cfg.en[0] ? 2'd0 : cfg.en[1] ? 2'd1 : cfg.en[2] ? 2'd2 : 2'd3;
  wire [1:0] hi_en    = cfg.en[3] ? 2'd3 : cfg.en[2] ? 2'd2 : cfg.en[1] ? 2'd1 : 2'd0;
  wire [2:0] en_count = {2'b00, cfg.en[0]} + {2'b00, cfg.en[1]} + {2'b00, cfg.en[2]}
                        + {2'b00, cfg.en[3]};
  wire [1:0] span     = dir_up ? last_pos - first_pos : first_pos - last_pos;
  wire [2:0] skips    = {1'b0, span} - (hits - 3'd1);
  wire strict_ok = dir_known && (hits == en_count)
                   && (first_pos == (dir_up ? lo_en : hi_en))
                   && (last_pos == (dir_up ? hi_en : lo_en));
  // two keys one gap apart, or three or four keys with at most one gap, either way round
  wire tolerant_ok = dir_known && (span >= 2'd2) && (skips <= 3'd1);
  wire done        = (state == tgr_pkg::TGR_TRACK) && tick && !timed_out && released;
  wire recog       = done && (cfg.mode ? tolerant_ok : strict_ok);
  wire tout_evt    = (state == tgr_pkg::TGR_TRACK) && tick && timed_out;
  wire step_bad    = dir_known && ((fresh_pos > last_pos) != dir_up);

  // sequence tracker, advanced once per sampling tick
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state      <= tgr_pkg::TGR_IDLE;
      prev_touch <= 4'h0;
      first_pos  <= 2'd0;
      last_pos   <= 2'd0;
      hits       <= 3'd0;
      dir_up     <= 1'b0;
      dir_known  <= 1'b0;
      dur        <= 12'h0;
    end else if (tick) begin
      prev_touch <= touch;
      case (state)
        tgr_pkg::TGR_IDLE: begin
          if (one_fresh) begin
            state     <= tgr_pkg::TGR_TRACK;
            first_pos <= fresh_pos;
            last_pos  <= fresh_pos;
            hits      <= 3'd1;
            dir_known <= 1'b0;
            dur       <= 12'h0;
          end else if (many_fresh) begin
            state <= tgr_pkg::TGR_WAIT;
          end
        end
        tgr_pkg::TGR_TRACK: begin
          if (dur != tgr_pkg::TGR_DUR_MAX)
            dur <= dur + 12'h001;
          if (timed_out) begin
            state <= tgr_pkg::TGR_WAIT;
          end else if (released) begin
            state <= tgr_pkg::TGR_IDLE;
          end else if (many_fresh || (one_fresh && step_bad)) begin
            // two keys at once or a turn-back spoils the sequence
            state <= tgr_pkg::TGR_WAIT;
          end else if (one_fresh && fresh_pos != last_pos) begin
            dir_known <= 1'b1;
            dir_up    <= dir_known ? dir_up : (fresh_pos > last_pos);
            last_pos  <= fresh_pos;
            hits      <= hits + 3'd1;
          end
        end
        tgr_pkg::TGR_WAIT: begin
          if (released)
            state <= tgr_pkg::TGR_IDLE;
        end
        default: state <= tgr_pkg::TGR_IDLE;
      endcase
    end
  end

  // result is held until a clear; a gesture landing with the clear wins
  wire hold_free = (!result.dir_a && !result.dir_b) || clear_trigger;
  wire take      = recog && hold_free;
  // the release tick itself counts, so the latched span is one past dur
  wire [11:0] dur_now = (dur == tgr_pkg::TGR_DUR_MAX) ? dur : dur + 12'h001;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      result <= '0;
    end else if (take) begin
      result.duration <= dur_now;
      result.dir_a    <= dir_up;
      result.dir_b    <= ~dir_up;
    end else if (clear_trigger) begin
      result <= '0;
    end
  end

  // sticky events; write-one-to-clear, a new event beats the clear
  wire [2:0] evt      = {tout_evt, take & ~dir_up, take & dir_up};
  wire [2:0] w1c      = (wr && hit_sts) ? pwdata[2:0] : 3'h0;
  wire [2:0] next_sts = (sts & ~w1c) | evt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sts <= 3'h0;
      irq <= 1'b0;
    end else begin
      sts <= next_sts;
      irq <= |(sts & mask);
    end
  end

  // checks
  chk_clear_self_return: assert property (@(posedge mclk) disable iff (rst)
    clear_trigger |=> !clear_trigger) else $error("clear strobe stuck high");

  chk_clear_wipes_result: assert property (@(posedge mclk) disable iff (rst)
    clear_trigger && !recog |=> result == '0) else $error("clear left result");

  chk_dir_one_flag: assert property (@(posedge mclk) disable iff (rst)
    !(result.dir_a && result.dir_b)) else $error("both direction flags set");

  chk_tick_spacing: assert property (@(posedge mclk) disable iff (rst)
    tick |=> (!tick)[*8]) else $error("sampling ticks too close");

  chk_timeout_abort: assert property (@(posedge mclk) disable iff (rst)
    tout_evt |=> state == tgr_pkg::TGR_WAIT && !$rose(result.dir_a | result.dir_b))
    else $error("overlong sequence not rejected");

  chk_strict_all_keys: assert property (@(posedge mclk) disable iff (rst)
    recog && !cfg.mode |-> hits == en_count) else $error("strict gesture missing keys");

  chk_strict_order: assert property (@(posedge mclk) disable iff (rst)
    recog && !cfg.mode && dir_up |-> first_pos == lo_en && last_pos == hi_en)
    else $error("strict forward order wrong");

  chk_tolerant_span: assert property (@(posedge mclk) disable iff (rst)
    recog && cfg.mode |-> span >= 2'd2 && skips <= 3'd1) else $error("tolerant match too short");

  chk_duration_latch: assert property (@(posedge mclk) disable iff (rst)
    take |=> result.duration == $past(dur) + 12'h001 && result.dir_a == $past(dir_up))
    else $error("duration not latched");

  chk_result_hold: assert property (@(posedge mclk) disable iff (rst)
    (result.dir_a || result.dir_b) && !clear_trigger |=> $stable(result))
    else $error("result changed without clear");

  chk_irq_follows: assert property (@(posedge mclk) disable iff (rst)
    ##1 irq == $past(|(sts & mask))) else $error("irq not tracking status");

endmodule

`default_nettype wire

//--- inc/tgr_pkg.sv
package tgr_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] TGR_IDX_DURATION  = 8'h60;
  localparam logic [7:0] TGR_IDX_DIRECTION = 8'h62;
  localparam logic [7:0] TGR_IDX_CLEAR     = 8'he2;
  localparam logic [7:0] TGR_IDX_CONFIG    = 8'he3;
  localparam logic [7:0] TGR_IDX_TIMEBASE  = 8'he4;
  localparam logic [7:0] TGR_IDX_TIMEOUT   = 8'he5;
  localparam logic [7:0] TGR_IDX_IRQ_STAT  = 8'h70;
  localparam logic [7:0] TGR_IDX_IRQ_MASK  = 8'h71;

  // field positions
  localparam int TGR_CLEAR_BIT = 7;
  localparam int TGR_MODE_BIT  = 4;
  localparam int TGR_DIR_A_BIT = 0;
  localparam int TGR_DIR_B_BIT = 1;
  localparam int TGR_STS_A     = 0;
  localparam int TGR_STS_B     = 1;
  localparam int TGR_STS_TOUT  = 2;

  // reset values
  localparam logic [4:0] TGR_CONFIG_RST   = 5'h1f;
  localparam logic [1:0] TGR_TIMEBASE_RST = 2'h2;
  localparam logic [7:0] TGR_TIMEOUT_RST  = 8'hff;
  localparam logic [2:0] TGR_MASK_RST     = 3'h0;

  // timing: sampling interval is 2*16*16 oscillator periods times 2**divider
  localparam int          TGR_OSC_PERIOD_NS = 10;
  localparam int          TGR_BASE_PERIODS  = 2 * 16 * 16;
  localparam logic [12:0] TGR_BASE_CYCLES   = 13'(TGR_BASE_PERIODS * TGR_OSC_PERIOD_NS / 10);
  localparam int          TGR_JUDGE_MULT_SH = 4;
  localparam logic [11:0] TGR_DUR_MAX       = 12'hfff;

  typedef struct packed {
    logic       mode;
    logic [3:0] en;
  } tgr_config_type;

  typedef struct packed {
    logic        dir_b;
    logic        dir_a;
    logic [11:0] duration;
  } tgr_result_type;

  typedef enum logic [1:0] {TGR_IDLE, TGR_TRACK, TGR_WAIT} tgr_state_type;

endpackage

//--- test/tb.sv
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic        mclk;
  logic        rst;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [3:0]  keys;
  logic        s0;
  logic        s2;
  logic        s4;
  logic        s6;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          checks_done;

  tgr_gesture dut (.mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_input_zero(s0), .sense_input_two(s2), .sense_input_four(s4),
    .sense_input_six(s6), .irq(irq));

  tgr_touch_model touch (.mclk(mclk), .rst(rst), .keys(keys), .sense_input_zero(s0),
    .sense_input_two(s2), .sense_input_four(s4), .sense_input_six(s6));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer, then one idle cycle so the next setup never collides
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: no pready", $time);
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  // press channels cumulatively one step apart, then release all together
  task automatic swipe(input logic [15:0] seq, input int n, input int step);
    for (int i = 0; i < n; i++) begin
      keys <= keys | seq[i*4 +: 4];
      repeat (step) @(posedge mclk);
    end
    keys <= 4'h0;
    repeat (3 * step) @(posedge mclk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp, input string what);
    apb(1'b0, idx, 32'h0);
    chk(rd, exp, what);
  endtask

  task automatic t_reset();
    rd_chk(tgr_pkg::TGR_IDX_DIRECTION, 32'h0, "direction at reset");
    rd_chk(tgr_pkg::TGR_IDX_CONFIG, 32'h0, "config reads zero");
    apb(1'b0, 8'h10, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped slverr");
    $display("test reset done");
  endtask

  // reset mode and time base first: 2048 cycles a tick, one tick a step;
  // then the fastest time base: 512 cycles a tick, 2 ticks a step
  task automatic t_tolerant();
    swipe({4'h0, 4'h4, 4'h2, 4'h1}, 3, 2048);
    rd_chk(tgr_pkg::TGR_IDX_DURATION, 32'h3, "default time base");
    apb(1'b1, tgr_pkg::TGR_IDX_CLEAR, 32'h80);
    apb(1'b1, tgr_pkg::TGR_IDX_IRQ_STAT, 32'h1);
    apb(1'b1, tgr_pkg::TGR_IDX_TIMEBASE, 32'h0);
    apb(1'b1, tgr_pkg::TGR_IDX_IRQ_MASK, 32'h1);
    swipe({4'h0, 4'h4, 4'h2, 4'h1}, 3, 1024);
    rd_chk(tgr_pkg::TGR_IDX_DIRECTION, 32'h1, "0-2-4 gives A");
    rd_chk(tgr_pkg::TGR_IDX_DURATION, 32'h6, "duration ticks");
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, tgr_pkg::TGR_IDX_IRQ_STAT, 32'h1);
    // irq lags status by one edge; look once it has settled
    @(posedge mclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("test tolerant done");
  endtask

  task automatic t_hold_clear();
    swipe({4'h0, 4'h2, 4'h4, 4'h8}, 3, 1024);
    rd_chk(tgr_pkg::TGR_IDX_DIRECTION, 32'h1, "result held");
    apb(1'b1, tgr_pkg::TGR_IDX_CLEAR, 32'h80);
    rd_chk(tgr_pkg::TGR_IDX_DIRECTION, 32'h0, "clear direction");
    rd_chk(tgr_pkg::TGR_IDX_DURATION, 32'h0, "clear duration");
    swipe({4'h0, 4'h1, 4'h4, 4'h8}, 3, 1024);
    rd_chk(tgr_pkg::TGR_IDX_DIRECTION, 32'h2, "6-4-0 after clear");
    chk({31'h0, irq}, 32'h0, "masked status");
    rd_chk(tgr_pkg::TGR_IDX_IRQ_STAT, 32'h2, "status B");
    $display("test hold and clear done");
  endtask

  task automatic t_strict();
    apb(1'b1, tgr_pkg::TGR_IDX_CLEAR, 32'h80);
    apb(1'b1, tgr_pkg::TGR_IDX_CONFIG, 32'h0f);
    swipe({4'h0, 4'h4, 4'h2, 4'h1}, 3, 1024);
    rd_chk(tgr_pkg::TGR_IDX_DIRECTION, 32'h0, "strict rejects skip");
    swipe({4'h8, 4'h4, 4'h2, 4'h1}, 4, 1024);
    rd_chk(tgr_pkg::TGR_IDX_DIRECTION, 32'h1, "strict A");
    rd_chk(tgr_pkg::TGR_IDX_DURATION, 32'h8, "strict duration");
    apb(1'b1, tgr_pkg::TGR_IDX_CLEAR, 32'h80);
    swipe({4'h1, 4'h2, 4'h4, 4'h8}, 4, 1024);
    rd_chk(tgr_pkg::TGR_IDX_DIRECTION, 32'h2, "strict B");
    apb(1'b1, tgr_pkg::TGR_IDX_CLEAR, 32'h80);
    apb(1'b1, tgr_pkg::TGR_IDX_CONFIG, 32'h06);
    swipe({4'h0, 4'h0, 4'h4, 4'h2}, 2, 1024);
    rd_chk(tgr_pkg::TGR_IDX_DIRECTION, 32'h1, "two enabled channels");
    $display("test strict done");
  endtask

  // limit of 16 ticks; three steps of 6 ticks run past it
  task automatic t_timeout();
    apb(1'b1, tgr_pkg::TGR_IDX_CLEAR, 32'h80);
    apb(1'b1, tgr_pkg::TGR_IDX_CONFIG, 32'h1f);
    apb(1'b1, tgr_pkg::TGR_IDX_IRQ_STAT, 32'h7);
    apb(1'b1, tgr_pkg::TGR_IDX_TIMEOUT, 32'h1);
    swipe({4'h0, 4'h4, 4'h2, 4'h1}, 3, 3072);
    rd_chk(tgr_pkg::TGR_IDX_DIRECTION, 32'h0, "too slow");
    rd_chk(tgr_pkg::TGR_IDX_IRQ_STAT, 32'h4, "timeout status");
    $display("test timeout done");
  endtask

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    keys = 4'h0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_tolerant();
    t_hold_clear();
    t_strict();
    t_timeout();
    wrap_up();
  end
endmodule

`default_nettype wire

//--- test/tgr_touch_model.sv
`timescale 1ns/100ps
`default_nettype none

// far side: button states of the four gesture channels
module tgr_touch_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic [3:0] keys,
  output logic            sense_input_zero,
  output logic            sense_input_two,
  output logic            sense_input_four,
  output logic            sense_input_six
);
  // registered so a button never moves on the edge that samples it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      {sense_input_six, sense_input_four, sense_input_two, sense_input_zero} <= 4'h0;
    end else begin
      {sense_input_six, sense_input_four, sense_input_two, sense_input_zero} <= keys;
    end
  end
endmodule

`default_nettype wire
